// ### design/dacsp_top.sv
/*
  Serial configuration port: header decode, register write and read-back,
  3/4-wire and bit-order selection, and combined reset generation.
  Assumes sclk, select, data and the reset pin are asynchronous to sys_clk_in
  and that sclk runs well below a quarter of the system clock.
*/
`timescale 1ns/1ns
module dacsp_top
(
  // Clock and power-on reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // External reset pin, active high
  input wire logic reset_pin_in,
  // Serial pins
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_out,
  output logic serial_data_out_pin_out,
  output logic serial_data_out_pin_oe_out,
  // Device side
  output logic dev_reset_out,
  output logic three_wire_out,
  output logic lsb_first_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [dacsp_pkg::SYNC_WIDTH-1:0] pins_in;
  logic [dacsp_pkg::SYNC_WIDTH-1:0] sync1_r;
  logic [dacsp_pkg::SYNC_WIDTH-1:0] sync2_r;
  logic sclk_prev_r;
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic rst_pin_s;
  logic sclk_rise;
  logic sclk_fall;

  assign pins_in = {reset_pin_in, sdio_in, spi_cs_n_in, spi_sclk_in};

  genvar gi;
  generate
    for (gi = 0; gi < dacsp_pkg::SYNC_WIDTH; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk_in)
      begin
        if (!rst_n_in)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= pins_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign sclk_s = sync2_r[0];
  assign cs_n_s = sync2_r[1];
  assign din_s = sync2_r[2];
  assign rst_pin_s = sync2_r[3];

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      sclk_prev_r <= 1'b0;
    else
      sclk_prev_r <= sclk_s;
  end

  // Edges count only while selected
  assign sclk_rise = sclk_s && !sclk_prev_r && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_prev_r && !cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Reset combination
  logic [2:0] format;
  logic soft_rst;
  logic int_rst_r;
  logic port_rst;

  assign soft_rst = format[dacsp_pkg::BIT_SOFT_RESET - 5];

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      int_rst_r <= 1'b1;
    else
      int_rst_r <= rst_pin_s || soft_rst;
  end

  // Pin reset also clears the serial engine; soft reset must not, or it could never be undone
  assign port_rst = !rst_n_in || rst_pin_s;

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine
  dacsp_pkg::dacsp_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] tx_r;
  logic [6:0] addr_r;
  logic wr_en_r;
  dacsp_pkg::dacsp_wr_t wr_r;
  logic [7:0] rd_data;
  logic lsb_first;
  logic three_wire;
  logic out_r;
  logic oe_r;

  assign three_wire = format[dacsp_pkg::BIT_THREE_WIRE - 5];
  assign lsb_first = format[dacsp_pkg::BIT_LSB_FIRST - 5];

  // Same shifter serves header and data
  assign shift_nxt = lsb_first ? {din_s, shift_r[7:1]} : {shift_r[6:0], din_s};

  always_ff @(posedge sys_clk_in)
  begin
    if (port_rst)
    begin
      state_r <= dacsp_pkg::ST_HEADER;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      addr_r <= 7'h00;
    end
    else if (cs_n_s)
    begin
      if (bit_cnt_r != 3'h0 || state_r == dacsp_pkg::ST_DONE)
      begin
        state_r <= dacsp_pkg::ST_HEADER;
        bit_cnt_r <= 3'h0;
      end
    end
    else if (sclk_rise)
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      case (state_r)
        dacsp_pkg::ST_HEADER:
        begin
          shift_r <= shift_nxt;
          if (bit_cnt_r == dacsp_pkg::LAST_BIT_IDX)
          begin
            addr_r <= shift_nxt[6:0];
            state_r <= shift_nxt[7] ? dacsp_pkg::ST_RDATA : dacsp_pkg::ST_WDATA;
          end
        end
        dacsp_pkg::ST_WDATA:
        begin
          shift_r <= shift_nxt;
          if (bit_cnt_r == dacsp_pkg::LAST_BIT_IDX)
            state_r <= dacsp_pkg::ST_DONE;
        end
        dacsp_pkg::ST_RDATA:
        begin
          if (bit_cnt_r == dacsp_pkg::LAST_BIT_IDX)
            state_r <= dacsp_pkg::ST_DONE;
        end
        dacsp_pkg::ST_DONE:
          bit_cnt_r <= 3'h0;
        default:
          state_r <= dacsp_pkg::ST_HEADER;
      endcase
    end
  end

  // Write strobe on the last data bit
  always_ff @(posedge sys_clk_in)
  begin
    if (port_rst)
    begin
      wr_en_r <= 1'b0;
      wr_r <= '0;
    end
    else
    begin
      wr_en_r <= sclk_rise && state_r == dacsp_pkg::ST_WDATA
        && bit_cnt_r == dacsp_pkg::LAST_BIT_IDX;
      wr_r <= '{addr: addr_r, data: shift_nxt};
    end
  end

  // Read shifter: load at header end, bit out on each falling edge
  always_ff @(posedge sys_clk_in)
  begin
    if (port_rst)
    begin
      tx_r <= 8'h00;
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else if (cs_n_s)
      oe_r <= 1'b0;
    else if (sclk_rise && state_r == dacsp_pkg::ST_HEADER
             && bit_cnt_r == dacsp_pkg::LAST_BIT_IDX)
      tx_r <= rd_data;
    else if (sclk_fall)
    begin
      if (state_r == dacsp_pkg::ST_RDATA)
      begin
        out_r <= lsb_first ? tx_r[0] : tx_r[7];
        tx_r <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
        oe_r <= 1'b1;
      end
      else
        oe_r <= 1'b0;
    end
  end

  dacsp_regfile u_regfile
  (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .blk_rst_in(int_rst_r),
    .wr_en_in(wr_en_r),
    .wr_in(wr_r),
    .rd_addr_in(shift_nxt[6:0]),
    .rd_data_out(rd_data),
    .format_out(format)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sdio_out = out_r;
  assign serial_data_out_pin_out = out_r;
  assign sdio_oe_out = oe_r && three_wire;
  assign serial_data_out_pin_oe_out = oe_r && !three_wire;
  assign dev_reset_out = int_rst_r;
  assign three_wire_out = three_wire;
  assign lsb_first_out = lsb_first;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_or: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (rst_pin_s || soft_rst) |=> dev_reset_out)
    else $error("internal reset missed a source");
  a_soft_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    soft_rst [*2] |-> dev_reset_out)
    else $error("soft reset bit set but device not held");
  a_three_sdo: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    three_wire |-> !serial_data_out_pin_oe_out)
    else $error("dedicated output driven in 3-wire mode");
  a_four_sdio: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !three_wire |-> !sdio_oe_out)
    else $error("data pin driven in 4-wire mode");
  a_oe_phase: assert property (@(posedge sys_clk_in) disable iff (port_rst)
    $rose(oe_r) |-> $past(state_r) == dacsp_pkg::ST_RDATA && $past(sclk_fall))
    else $error("output enabled outside read data");
  a_sel_idle: assert property (@(posedge sys_clk_in) disable iff (port_rst)
    cs_n_s |=> !sdio_oe_out && !serial_data_out_pin_oe_out)
    else $error("output driven while deselected");
  a_midbyte_rst: assert property (@(posedge sys_clk_in) disable iff (port_rst)
    (cs_n_s && bit_cnt_r != 3'h0) |=> state_r == dacsp_pkg::ST_HEADER
      && bit_cnt_r == 3'h0)
    else $error("mid-byte deselect did not reset the port");
  a_pause_hold: assert property (@(posedge sys_clk_in) disable iff (port_rst)
    (cs_n_s && bit_cnt_r == 3'h0 && state_r == dacsp_pkg::ST_WDATA)
      |=> state_r == dacsp_pkg::ST_WDATA)
    else $error("byte-boundary pause lost the transfer");
  a_write_time: assert property (@(posedge sys_clk_in) disable iff (port_rst)
    wr_en_r |-> $past(state_r) == dacsp_pkg::ST_WDATA && $past(sclk_rise)
      && $past(bit_cnt_r) == dacsp_pkg::LAST_BIT_IDX)
    else $error("write strobe not on last data bit");
  a_dir_decode: assert property (@(posedge sys_clk_in) disable iff (port_rst)
    (sclk_rise && state_r == dacsp_pkg::ST_HEADER && bit_cnt_r == dacsp_pkg::LAST_BIT_IDX)
      |=> state_r == (shift_r[7] ? dacsp_pkg::ST_RDATA : dacsp_pkg::ST_WDATA)
        && addr_r == shift_r[6:0])
    else $error("header decoded wrongly");
endmodule : dacsp_top

// ### include/dacsp_pkg.sv
/*
  Constants and types shared by the serial configuration port.
  Assumes a single 250 MHz system clock; all serial pins are asynchronous to it.
*/
package dacsp_pkg;
  // Register map
  localparam logic [6:0] REG_FORMAT_ADDR = 7'h00;
  localparam int unsigned NUM_REGS = 32;
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  // Format register fields
  localparam int unsigned BIT_THREE_WIRE = 7;
  localparam int unsigned BIT_LSB_FIRST = 6;
  localparam int unsigned BIT_SOFT_RESET = 5;
  // Serial framing
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam int unsigned SYNC_WIDTH = 4;

  typedef enum logic [1:0]
  {
    ST_HEADER = 2'b00,
    ST_WDATA = 2'b01,
    ST_RDATA = 2'b10,
    ST_DONE = 2'b11
  } dacsp_state_t;

  typedef struct packed
  {
    logic [6:0] addr;
    logic [7:0] data;
  } dacsp_wr_t;
endpackage : dacsp_pkg

// ### design/dacsp_regfile.sv
/*
  Configuration register storage for the serial port.
  Assumes writes arrive as single-cycle strobes from the serial engine.
*/
`timescale 1ns/1ns
module dacsp_regfile
(
  // Clock and resets
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic blk_rst_in,
  // Write port
  input wire logic wr_en_in,
  input wire dacsp_pkg::dacsp_wr_t wr_in,
  // Read port
  input wire logic [6:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  // Format register fields
  output logic [2:0] format_out
);
  logic [2:0] format_r;
  logic [7:0] regs_r [1:dacsp_pkg::NUM_REGS-1];

  // Format register survives pin and soft reset; only power-on clears it
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      format_r <= dacsp_pkg::FORMAT_RESET[7:5];
    else if (wr_en_in && wr_in.addr == dacsp_pkg::REG_FORMAT_ADDR)
      format_r <= wr_in.data[7:5];
  end

  genvar gi;
  generate
    for (gi = 1; gi < dacsp_pkg::NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge sys_clk_in)
      begin
        if (!rst_n_in || blk_rst_in)
          regs_r[gi] <= dacsp_pkg::REG_DEFAULT;
        else if (wr_en_in && wr_in.addr == 7'(gi))
          regs_r[gi] <= wr_in.data;
      end
    end
  endgenerate

  always_comb
  begin
    if (rd_addr_in == dacsp_pkg::REG_FORMAT_ADDR)
      rd_data_out = {format_r, 5'h00};
    else if (rd_addr_in < 7'(dacsp_pkg::NUM_REGS))
      rd_data_out = regs_r[rd_addr_in[4:0]];
    else
      rd_data_out = 8'h00;
  end

  assign format_out = format_r;

  a_format_keep: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (blk_rst_in && !wr_en_in) |=> format_r == $past(format_r))
    else $error("format register changed under block reset");
endmodule : dacsp_regfile

// ### test/dacsp_host_model.sv
/*
  Serial master model that drives the port pins and captures read bytes.
  Assumes a 250 MHz clock; each sclk phase lasts 8 clocks.
*/
`timescale 1ns/1ns
module dacsp_host_model
(
  // Clock
  input wire logic clk_in,
  // Pins toward the port
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdio_out,
  output logic sdio_oe_out,
  input wire logic miso_in,
  // Captured read byte
  output logic [7:0] rd_byte_out,
  output logic rd_valid_out
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdio_out = 1'b0;
    sdio_oe_out = 1'b0;
    rd_byte_out = 8'h00;
    rd_valid_out = 1'b0;
  end

  // Half period of 8 clocks keeps sclk under 20 MHz
  task automatic half();
    repeat (8) @(posedge clk_in);
  endtask : half

  // Released line shows the inverse of its last value
  task automatic bit_io(input logic b, input logic drv, output logic s);
    sdio_out <= drv ? b : ~sdio_out;
    sdio_oe_out <= drv;
    half();
    sclk_out <= 1'b1;
    s = miso_in;
    half();
    sclk_out <= 1'b0;
  endtask : bit_io

  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
    input logic lsb, input int nbits, input logic pause);
    logic [15:0] w;
    logic [7:0] r;
    logic s;
    int i;
    int k;
    w = {rd, a, d};
    r = 8'h00;
    cs_n_out <= 1'b0;
    for (i = 0; i < nbits; i++)
    begin
      if (pause && i == 8)
      begin
        cs_n_out <= 1'b1;
        repeat (20) @(posedge clk_in);
        cs_n_out <= 1'b0;
      end
      k = lsb ? (i < 8 ? i + 8 : i - 8) : 15 - i;
      bit_io(w[k], !(rd && i >= 8), s);
      if (i >= 8)
        r[k] = s;
    end
    half();
    cs_n_out <= 1'b1;
    sdio_oe_out <= 1'b0;
    sdio_out <= ~sdio_out;
    if (rd && nbits == 16)
    begin
      rd_byte_out <= r;
      rd_valid_out <= 1'b1;
      @(posedge clk_in);
      rd_valid_out <= 1'b0;
    end
    repeat (16) @(posedge clk_in);
  endtask : xfer
endmodule : dacsp_host_model

// ### test/test_dac_serial_config_port.sv
/*
  Self-checking bench for the serial configuration port.
  Assumes the host model drives all serial pins; reads are checked from a queue.
*/
`timescale 1ns/1ns
module test_dac_serial_config_port;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reset_pin_in = 1'b0;
  logic sclk, cs_n, h_sdio, h_oe, sdio_o, sdio_oe, serial_data_out_pin, sdo_oe, dev_rst, three, lsb;
  logic rd_valid, sdio_w, miso;
  logic [7:0] rd_byte;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int check_count = 0;
  int seed = 53505;

  assign sdio_w = sdio_oe ? sdio_o : h_sdio;
  assign miso = three ? sdio_w : (sdo_oe ? serial_data_out_pin : ~serial_data_out_pin);

  initial
    forever #2 sys_clk_in = ~sys_clk_in;

  dacsp_top i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reset_pin_in(reset_pin_in),
    .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .sdio_in(sdio_w), .sdio_out(sdio_o),
    .sdio_oe_out(sdio_oe), .serial_data_out_pin_out(serial_data_out_pin), .serial_data_out_pin_oe_out(sdo_oe),
    .dev_reset_out(dev_rst), .three_wire_out(three), .lsb_first_out(lsb));

  dacsp_host_model u_host (.clk_in(sys_clk_in), .sclk_out(sclk), .cs_n_out(cs_n),
    .sdio_out(h_sdio), .sdio_oe_out(h_oe), .miso_in(miso), .rd_byte_out(rd_byte),
    .rd_valid_out(rd_valid));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic l);
    u_host.xfer(1'b0, a, d, l, 16, 1'b0);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic l);
    exp_q.push_back(e);
    u_host.xfer(1'b1, a, 8'h00, l, 16, 1'b0);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in)
  begin
    if (rd_valid)
      check(rd_byte, exp_q.pop_front());
    check({7'h00, sdo_oe & three}, 8'h00);
    check({7'h00, sdio_oe & ~three}, 8'h00);
    check({7'h00, (sdo_oe | sdio_oe) & h_oe}, 8'h00);
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk_in);
    num_errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [6:0] a;
    logic [7:0] d;
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    check({5'h00, dev_rst, three, lsb}, 8'h00);
    rd(7'h00, 8'h00, 1'b0);
    repeat (12)
    begin
      a = 7'(1 + ($unsigned($random(seed)) % 31));
      d = 8'($random(seed));
      wr(a, d, 1'b0);
      rd(a, d, 1'b0);
    end
    u_host.xfer(1'b0, 7'h03, 8'h5a, 1'b0, 16, 1'b1);
    rd(7'h03, 8'h5a, 1'b0);
    u_host.xfer(1'b0, 7'h03, 8'ha5, 1'b0, 12, 1'b0);
    rd(7'h03, 8'h5a, 1'b0);
    wr(7'h01, 8'hff, 1'b0);
    rd(7'h41, 8'h00, 1'b0);
    wr(7'h00, 8'h42, 1'b0);
    check({7'h00, lsb}, 8'h01);
    rd(7'h00, 8'h40, 1'b1);
    d = 8'($random(seed));
    wr(7'h04, d, 1'b1);
    rd(7'h04, d, 1'b1);
    wr(7'h00, 8'h84, 1'b1);
    check({6'h00, three, lsb}, 8'h02);
    rd(7'h04, d, 1'b0);
    wr(7'h00, 8'h24, 1'b0);
    check({7'h00, dev_rst}, 8'h01);
    wr(7'h00, 8'h00, 1'b0);
    check({7'h00, dev_rst}, 8'h00);
    rd(7'h04, 8'h00, 1'b0);
    wr(7'h00, 8'h42, 1'b0);
    wr(7'h04, d, 1'b1);
    reset_pin_in <= 1'b1;
    repeat (12) @(posedge sys_clk_in);
    check({7'h00, dev_rst}, 8'h01);
    reset_pin_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    check({7'h00, lsb}, 8'h01);
    rd(7'h04, 8'h00, 1'b1);
    end_of_test();
  end
endmodule : test_dac_serial_config_port
